// ==== gwcw_regs.vh ====
// Constants for the gateway control word decoder: offsets, fields, codes.
// Assumes byte-wide access to the output process area.
`ifndef GWCW_REGS_VH
`define GWCW_REGS_VH
`define OFS_CTRL_HI 10'h200
`define OFS_CTRL_LO 10'h201
`define OFS_STAT_HI 10'h000
`define OFS_STAT_LO 10'h001
`define BIT_HCONFIRM 15
`define BIT_HSEND 14
`define BIT_OUT_VALID 13
`define BIT_EXEC 12
`define CODE_MSB 11
`define CODE_LSB 8
`define OPND_MSB 7
`define OPND_LSB 0
`define CMD_DISABLE 4'h0
`define CMD_ENABLE 4'h1
`define CMD_FIRST_N 4'h2
`define MODE_MASTER 2'h0
`define MODE_SERIAL 2'h1
`define MODE_GENERIC 2'h2
`define HDR_WORDS 8'h10
`define DATA_WORDS_MAX 8'h80
`define MSG_INFO_FIXED 16'h4002
`define HDR_IDX_INFO 4'h1
`define HDR_IDX_SIZE 4'h3
`endif

// ==== node_mask_mem.v ====
// Node enable memory: one bit for each of 256 subnetwork node addresses.
// Assumes a single clock; read data registered one cycle after the address.
`timescale 1ns/100ps
module node_mask_mem (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire wr_i,
	input wire [7:0] waddr_i,
	input wire wdata_i,
	input wire [7:0] raddr_i,
	output reg rdata_o
);
	reg [255:0] mask_ff;
	// -----------------------------------------------------------------
	// Storage; all nodes start enabled after reset.
	// -----------------------------------------------------------------
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mask_ff <= {256{1'b1}};
			rdata_o <= 1'b1;
		end else begin
			if (wr_i)
				mask_ff[waddr_i] <= wdata_i;
			rdata_o <= mask_ff[raddr_i]; // Registered read port.
		end
	end
endmodule

// ==== mbox_hdr_check.v ====
// Mailbox header checker: watches header words and flags a bad message.
// Assumes words arrive one a cycle with a start pulse on the first one.
`include "gwcw_regs.vh"
`timescale 1ns/100ps
module mbox_hdr_check (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire word_vld_i,
	input wire word_first_i,
	input wire [15:0] word_i,
	output reg msg_ok_o,
	output reg msg_bad_o
);
	reg [7:0] idx_ff;
	reg bad_ff;
	reg [7:0] nxt_idx;
	reg nxt_bad;
	// -----------------------------------------------------------------
	// Header walk. The size word counts data bytes, so words are halved.
	// -----------------------------------------------------------------
	always @* begin
		nxt_idx = word_first_i ? 8'h00 : idx_ff;
		nxt_bad = word_first_i ? 1'b0 : bad_ff;
		if (nxt_idx == {4'h0, `HDR_IDX_INFO} && word_i != `MSG_INFO_FIXED)
			nxt_bad = 1'b1;
		// Widened by one bit so a size of all ones cannot wrap to zero.
		if (nxt_idx == {4'h0, `HDR_IDX_SIZE}
			&& (({1'b0, word_i} + 17'h00001) >> 1) > {9'h000, `DATA_WORDS_MAX})
			nxt_bad = 1'b1;
	end
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			idx_ff <= 8'h00;
			bad_ff <= 1'b0;
			msg_ok_o <= 1'b0;
			msg_bad_o <= 1'b0;
		end else begin
			msg_ok_o <= 1'b0;
			msg_bad_o <= 1'b0;
			if (word_vld_i) begin
				idx_ff <= nxt_idx + 8'h01;
				bad_ff <= nxt_bad;
				// Verdict when the sixteenth header word is seen.
				if (nxt_idx == `HDR_WORDS - 8'h01) begin
					msg_ok_o <= !nxt_bad;
					msg_bad_o <= nxt_bad;
				end
			end
		end
	end
endmodule

// ==== gateway_control_word_decoder.v ====
// Control word decoder: captures the host control word from the output area,
// runs the handshake toggles and executes node enable commands.
// Assumes byte writes from the fieldbus side on core_clk_i's domain.
`include "gwcw_regs.vh"
`timescale 1ns/100ps
module gateway_control_word_decoder (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire cs_enable_i,
	input wire [1:0] op_mode_i,
	input wire area_wr_i,
	input wire [9:0] area_addr_i,
	input wire [7:0] area_wdata_i,
	input wire area_rd_i,
	output reg [7:0] area_rdata_o,
	input wire [7:0] node_count_i,
	input wire [7:0] node_query_i,
	output wire node_enabled_o,
	output reg sub_exchange_o,
	output reg cmd_busy_o,
	output reg cmd_done_o,
	input wire dev_send_tgl_i,
	input wire [12:0] dev_status_i,
	input wire mbox_vld_i,
	input wire mbox_first_i,
	input wire [15:0] mbox_word_i,
	output wire mbox_ok_o,
	output wire mbox_bad_o
);
	localparam ST_IDLE = 2'b00;
	localparam ST_FILL = 2'b01;
	localparam ST_DONE = 2'b10;

	reg [15:0] ctrl_ff;
	reg send_seen_ff;
	reg dev_confirm_ff;
	reg dev_send_ff;
	reg [1:0] state_ff;
	reg [7:0] fill_ff;
	reg [7:0] limit_ff;
	reg mem_wr;
	reg [7:0] mem_waddr;
	reg mem_wdata;
	wire host_confirm_toggle;
	wire host_send_toggle;
	wire [3:0] cmd_code;
	wire [7:0] cmd_opnd;
	wire cmd_allowed;
	wire new_send;

	// -----------------------------------------------------------------
	// Field extraction.
	// -----------------------------------------------------------------
	// Fields of the captured word.
	assign host_confirm_toggle = ctrl_ff[`BIT_HCONFIRM];
	assign host_send_toggle = ctrl_ff[`BIT_HSEND];
	assign cmd_code = ctrl_ff[`CODE_MSB:`CODE_LSB];
	assign cmd_opnd = ctrl_ff[`OPND_MSB:`OPND_LSB];
	// Commands only exist in the two master modes.
	assign cmd_allowed = cs_enable_i && (op_mode_i == `MODE_MASTER
		|| op_mode_i == `MODE_SERIAL);
	// A fresh request is a send toggle the device has not answered.
	assign new_send = host_send_toggle != send_seen_ff;

	// -----------------------------------------------------------------
	// Output area write port.
	// -----------------------------------------------------------------
	// High byte at the lower address, as the word is kept MSB first.
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_ff <= 16'h0000;
		end else if (area_wr_i && cs_enable_i) begin
			if (area_addr_i == `OFS_CTRL_HI)
				ctrl_ff[15:8] <= area_wdata_i;
			else if (area_addr_i == `OFS_CTRL_LO)
				ctrl_ff[7:0] <= area_wdata_i;
		end
	end

	// -----------------------------------------------------------------
	// Read port: status word and readback of the control word.
	// -----------------------------------------------------------------
	// Unmapped bytes read zero, so software sees no stale data.
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			area_rdata_o <= 8'h00;
		end else if (area_rd_i) begin
			if (cs_enable_i && area_addr_i == `OFS_STAT_HI)
				// Bit 13 of the status word is not driven by this block.
				area_rdata_o <= {dev_send_ff, dev_confirm_ff, 1'b0, dev_status_i[12:8]};
			else if (cs_enable_i && area_addr_i == `OFS_STAT_LO)
				area_rdata_o <= dev_status_i[7:0];
			else if (area_addr_i == `OFS_CTRL_HI)
				area_rdata_o <= ctrl_ff[15:8];
			else if (area_addr_i == `OFS_CTRL_LO)
				area_rdata_o <= ctrl_ff[7:0];
			else
				area_rdata_o <= 8'h00;
		end
	end

	// -----------------------------------------------------------------
	// Subnetwork exchange gate.
	// -----------------------------------------------------------------
	// With the words disabled there is no valid bit, so exchange runs freely.
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			sub_exchange_o <= 1'b0;
		else
			sub_exchange_o <= cs_enable_i ? ctrl_ff[`BIT_OUT_VALID] : 1'b1;
	end

	// -----------------------------------------------------------------
	// Device handshake bits.
	// -----------------------------------------------------------------
	// The device echoes the host send toggle as its confirm once the
	// request is consumed; its own send bit follows the core's toggle.
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dev_send_ff <= 1'b0;
			dev_confirm_ff <= 1'b0;
		end else begin
			dev_send_ff <= dev_send_tgl_i;
			if (state_ff == ST_IDLE && new_send)
				dev_confirm_ff <= host_send_toggle;
		end
	end

	// -----------------------------------------------------------------
	// Command engine.
	// -----------------------------------------------------------------
	// Code 0x02 walks every configured node, one per cycle, so it takes
	// node_count_i cycles; busy covers the walk.
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff <= ST_IDLE;
			send_seen_ff <= 1'b0;
			fill_ff <= 8'h00;
			limit_ff <= 8'h00;
			cmd_done_o <= 1'b0;
		end else begin
			cmd_done_o <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					if (new_send) begin
						send_seen_ff <= host_send_toggle;
						if (ctrl_ff[`BIT_EXEC] && cmd_allowed) begin
							if (cmd_code == `CMD_FIRST_N && node_count_i != 8'h00) begin
								fill_ff <= 8'h00;
								limit_ff <= cmd_opnd;
								state_ff <= ST_FILL;
							end else begin
								state_ff <= ST_DONE;
							end
						end
					end
				end
				ST_FILL: begin
					fill_ff <= fill_ff + 8'h01;
					if (fill_ff == node_count_i - 8'h01)
						state_ff <= ST_DONE;
				end
				ST_DONE: begin
					cmd_done_o <= 1'b1;
					state_ff <= ST_IDLE;
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Busy flag is a register so it is glitch free.
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			cmd_busy_o <= 1'b0;
		else
			cmd_busy_o <= (state_ff == ST_FILL) || (state_ff == ST_IDLE && new_send
				&& ctrl_ff[`BIT_EXEC] && cmd_allowed);
	end

	// -----------------------------------------------------------------
	// Node mask write selection.
	// -----------------------------------------------------------------
	always @* begin
		mem_wr = 1'b0;
		mem_waddr = cmd_opnd;
		mem_wdata = 1'b0;
		if (state_ff == ST_IDLE && new_send && ctrl_ff[`BIT_EXEC] && cmd_allowed) begin
			if (cmd_code == `CMD_DISABLE) begin
				mem_wr = 1'b1;
				mem_wdata = 1'b0;
			end else if (cmd_code == `CMD_ENABLE) begin
				mem_wr = 1'b1;
				mem_wdata = 1'b1;
			end
		end else if (state_ff == ST_FILL) begin
			mem_wr = 1'b1;
			mem_waddr = fill_ff;
			mem_wdata = fill_ff < limit_ff;
		end
	end

	node_mask_mem u_mask (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.wr_i(mem_wr),
		.waddr_i(mem_waddr),
		.wdata_i(mem_wdata),
		.raddr_i(node_query_i),
		.rdata_o(node_enabled_o)
	);

	// -----------------------------------------------------------------
	// Mailbox header checking.
	// -----------------------------------------------------------------
	mbox_hdr_check u_mbox (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.word_vld_i(mbox_vld_i),
		.word_first_i(mbox_first_i),
		.word_i(mbox_word_i),
		.msg_ok_o(mbox_ok_o),
		.msg_bad_o(mbox_bad_o)
	);
endmodule

// ==== gwcw_chk.sv ====
// Port checker for the control word decoder.
// Assumes one clock and the decoder's asynchronous active-low reset.
`timescale 1ns/100ps
`include "gwcw_regs.vh"
module gwcw_chk (
	input wire logic core_clk_i, arst_n_i, cs_enable_i, area_wr_i, area_rd_i,
	input wire logic [1:0] op_mode_i,
	input wire logic [9:0] area_addr_i,
	input wire logic [7:0] area_wdata_i, area_rdata_o, node_count_i, node_query_i,
	input wire logic node_enabled_o, sub_exchange_o, cmd_busy_o, cmd_done_o, dev_send_tgl_i,
	input wire logic mbox_vld_i, mbox_first_i, mbox_ok_o, mbox_bad_o,
	input wire logic [12:0] dev_status_i,
	input wire logic [15:0] mbox_word_i
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// ----
	// Assertions; the bound on done covers a full walk of 255 nodes.
	// ----
	busy_done_a: assert property ($rose(cmd_busy_o) |-> ##[1:300] cmd_done_o)
		else $error("command did not finish");
	done_once_a: assert property (cmd_done_o |=> !cmd_done_o)
		else $error("done longer than one cycle");
	cmd_mode_a: assert property ($rose(cmd_busy_o) |-> $past(cs_enable_i) && !$past(op_mode_i[1]))
		else $error("command ran outside master modes");
	exch_free_a: assert property ($past(arst_n_i) && !$past(cs_enable_i) |-> sub_exchange_o)
		else $error("exchange blocked with words disabled");
	rd_zero_a: assert property ($past(area_rd_i) && $past(area_addr_i) == 10'h155 |-> area_rdata_o == 8'h00)
		else $error("unmapped byte not zero");
	stat_byte_a: assert property ($past(area_rd_i) && $past(cs_enable_i) && $past(area_addr_i) == `OFS_STAT_HI
		|-> area_rdata_o[7] == $past(dev_send_tgl_i, 2) && area_rdata_o[4:0] == $past(dev_status_i[12:8]))
		else $error("status byte wrong");
	mbox_once_a: assert property (mbox_ok_o || mbox_bad_o |=> !(mbox_ok_o || mbox_bad_o))
		else $error("verdict longer than one cycle");
	mbox_excl_a: assert property (!(mbox_ok_o && mbox_bad_o))
		else $error("both verdicts at once");
	cover property ($rose(cmd_busy_o));
	cover property (mbox_ok_o);
	cover property (mbox_bad_o);
endmodule
bind gateway_control_word_decoder gwcw_chk u_gwcw_chk (.*);

// ==== fieldbus_host.sv ====
// Fieldbus master model: byte writes and reads into the output area.
// Assumes the decoder samples its strobes on the rising clock edge.
`timescale 1ns/100ps
`include "gwcw_regs.vh"
module fieldbus_host (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0,
	output logic [9:0] addr_o = 10'h3FF,
	output logic [7:0] wdata_o = 8'hA5
);
	// ----
	// Byte access; lines are scrambled once released so stale bytes never match.
	// ----
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	// Low byte first, so the send toggle in the high byte lands last.
	task automatic wr_word(input logic [15:0] w);
		wr(`OFS_CTRL_LO, w[7:0]);
		wr(`OFS_CTRL_HI, w[15:8]);
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(negedge clk_i);
		d = rdata_i;
	endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the control word decoder.
// Assumes the host model drives the byte port and the checker is bound.
`timescale 1ns/100ps
`include "gwcw_regs.vh"
module testbench;
	logic core_clk_i, arst_n_i, cs_enable_i, area_wr_i, area_rd_i, dev_send_tgl_i, snd;
	logic mbox_vld_i, mbox_first_i, node_enabled_o, sub_exchange_o, cmd_busy_o, cmd_done_o;
	logic mbox_ok_o, mbox_bad_o;
	logic [1:0] op_mode_i;
	logic [9:0] area_addr_i;
	logic [7:0] area_wdata_i, area_rdata_o, node_count_i, node_query_i, b;
	logic [12:0] dev_status_i;
	logic [15:0] mbox_word_i;
	int mismatches, checks, i;
	gateway_control_word_decoder u_gateway_control_word_decoder (.*);
	fieldbus_host u_fieldbus_host (.clk_i(core_clk_i), .rdata_i(area_rdata_o), .wr_o(area_wr_i),
		.rd_o(area_rd_i), .addr_o(area_addr_i), .wdata_o(area_wdata_i));
	// ----
	// Helpers.
	// ----
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// The mask read is registered, so the query is held two edges.
	task automatic q(input logic [7:0] n, input logic e);
		@(posedge core_clk_i) node_query_i <= n;
		repeat (2) @(posedge core_clk_i);
		@(negedge core_clk_i) chk(node_enabled_o, e);
	endtask
	// A refused command never pulses done, so that wait runs to its limit.
	task automatic cmd(input logic [3:0] code, input logic [7:0] opnd, input logic e);
		snd = ~snd;
		u_fieldbus_host.wr_word({1'b0, snd, 2'b11, code, opnd});
		for (i = 0; i < 300 && cmd_done_o !== 1'b1; i++)
			@(negedge core_clk_i);
		chk(cmd_done_o, e);
		chk(cmd_busy_o, 1'b0);
	endtask
	task automatic mb(input logic [15:0] info, input logic [15:0] size, input logic ok);
		for (i = 0; i < 16; i++) begin
			@(posedge core_clk_i);
			mbox_vld_i <= 1'b1;
			mbox_first_i <= (i == 0);
			mbox_word_i <= (i == 1) ? info : (i == 3) ? size : 16'(i);
		end
		@(posedge core_clk_i) mbox_vld_i <= 1'b0;
		for (i = 0; i < 4 && mbox_ok_o !== 1'b1 && mbox_bad_o !== 1'b1; i++)
			@(negedge core_clk_i);
		chk({mbox_ok_o, mbox_bad_o}, {ok, ~ok});
	endtask
	initial begin
		repeat (20000) @(posedge core_clk_i);
		mismatches++;
		test_done;
	end
	// ----
	// Main sequence.
	// ----
	initial begin
		{mbox_vld_i, mbox_first_i, mbox_word_i, node_query_i, snd} = '0;
		arst_n_i = 1'b1;
		{cs_enable_i, dev_send_tgl_i, op_mode_i, node_count_i} = {2'b11, `MODE_MASTER, 8'h04};
		dev_status_i = 13'h1F3C;
		// Reset falls on a clock edge so the design sees a clean falling edge.
		@(posedge core_clk_i) arst_n_i <= 1'b0;
		repeat (5) @(posedge core_clk_i);
		@(negedge core_clk_i) chk({area_rdata_o, node_enabled_o, sub_exchange_o}, 16'h0002);
		@(posedge core_clk_i) arst_n_i <= 1'b1;
		cmd(`CMD_DISABLE, 8'h05, 1'b1);
		q(8'h05, 1'b0);
		q(8'h06, 1'b1);
		cmd(`CMD_ENABLE, 8'h05, 1'b1);
		q(8'h05, 1'b0 + 1'b1);
		u_fieldbus_host.wr_word({1'b0, snd, 2'b11, `CMD_DISABLE, 8'h07});
		q(8'h07, 1'b1);
		cmd(`CMD_FIRST_N, 8'h02, 1'b1);
		q(8'h01, 1'b1);
		q(8'h02, 1'b0);
		q(8'h03, 1'b0);
		q(8'h05, 1'b1);
		@(posedge core_clk_i) op_mode_i <= `MODE_GENERIC;
		cmd(`CMD_DISABLE, 8'h00, 1'b0);
		q(8'h00, 1'b1);
		@(posedge core_clk_i) op_mode_i <= `MODE_SERIAL;
		cmd(`CMD_DISABLE, 8'h00, 1'b1);
		q(8'h00, 1'b0);
		u_fieldbus_host.rd(`OFS_STAT_HI, b);
		chk(b & 8'hDF, {1'b1, snd, 6'h1F});
		u_fieldbus_host.rd(`OFS_STAT_LO, b);
		chk(b, 8'h3C);
		u_fieldbus_host.rd(10'h155, b);
		chk(b, 8'h00);
		u_fieldbus_host.wr_word({1'b0, snd, 14'h0000});
		repeat (3) @(negedge core_clk_i);
		chk(sub_exchange_o, 1'b0);
		u_fieldbus_host.wr_word({1'b0, snd, 14'h2000});
		repeat (3) @(negedge core_clk_i);
		chk(sub_exchange_o, 1'b1);
		@(posedge core_clk_i) cs_enable_i <= 1'b0;
		u_fieldbus_host.wr_word({1'b0, snd, 14'h0000});
		repeat (3) @(negedge core_clk_i);
		chk(sub_exchange_o, 1'b1);
		u_fieldbus_host.rd(`OFS_STAT_HI, b);
		chk(b, 8'h00);
		@(posedge core_clk_i) cs_enable_i <= 1'b1;
		mb(`MSG_INFO_FIXED, 16'h0100, 1'b1);
		mb(16'h4012, 16'h0004, 1'b0);
		mb(`MSG_INFO_FIXED, 16'h0102, 1'b0);
		test_done;
	end
endmodule
